// >>> bench/mbw_chk.sv
// port checker for the write-multiple handler
`timescale 1ns/1ps
module mbw_chk (
    // clock, reset
    input wire logic clock_i,
    input wire logic rst_i,
    // reply stream
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_last_o,
    input wire logic tx_ready_i,
    // writes
    input wire logic wr_en_o,
    input wire mbw_pkg::reg_write_s wr_o
);
    logic [4:0] n;
    logic exc;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // byte index lets each reply field be checked by position
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            n <= 5'h00;
        else if (tx_valid_o && tx_ready_i)
            n <= tx_last_o ? 5'h00 : n + 5'h01;
        if (tx_valid_o && n == 5'h07)
            exc <= tx_data_o[7];
    end
    reply_stand_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_last_o, tx_data_o}))
        else $error("reply byte moved");
    wr_gap_a: assert property (wr_en_o |=> !wr_en_o) else $error("write pulse long");
    wr_step_a: assert property (wr_en_o ##2 wr_en_o |-> wr_o.addr == $past(wr_o.addr, 2) + 16'h0001)
        else $error("write address step");
    wr_quiet_a: assert property (tx_valid_o && n != 5'h00 |-> !wr_en_o) else $error("write in reply");
    fn_code_a: assert property (tx_valid_o && n == 5'h07 |-> tx_data_o inside {8'h10, 8'h90})
        else $error("reply code");
    exc_code_a: assert property (tx_valid_o && n == 5'h08 && exc |-> tx_last_o && tx_data_o inside {8'h01, 8'h02})
        else $error("exception code");
    last_pos_a: assert property (tx_valid_o && tx_last_o |-> n == (exc ? 5'h08 : 5'h0b)) else $error("reply length");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !tx_valid_o && !wr_en_o)
        else $error("busy after reset");
    cover property (tx_valid_o && tx_ready_i && tx_last_o && exc);
    cover property (tx_valid_o && tx_ready_i && tx_last_o && !exc);
    cover property (wr_en_o ##2 wr_en_o);
endmodule : mbw_chk
bind modbus_write_multiple_handler mbw_chk u_chk (.*);

// >>> bench/mbw_host.sv
// host model: sends request frames, sinks replies
`timescale 1ns/1ps
module mbw_host (
    // clock
    input wire logic clock_i,
    // request stream
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_last_o,
    input wire logic rx_ready_i,
    // reply sink, stalls on alternate cycles when slow
    output logic tx_ready_o,
    input wire logic slow_i
);
    initial {rx_valid_o, rx_last_o, tx_ready_o, rx_data_o} = 11'h000;
    always @(posedge clock_i) tx_ready_o <= #1 !slow_i || !tx_ready_o;
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i])
        begin
            rx_valid_o = 1'b1;
            rx_data_o = f[i];
            rx_last_o = i == f.size() - 1;
            do @(posedge clock_i); while (!rx_ready_i);
            #1;
        end
        // released line shows the inverse, never a stale byte
        rx_valid_o = 1'b0;
        rx_data_o = ~rx_data_o;
        rx_last_o = 1'b0;
    endtask : send
endmodule : mbw_host

// >>> bench/modbus_write_multiple_handler_tb_top.sv
// testbench for the write-multiple handler
`timescale 1ns/1ps
module modbus_write_multiple_handler_tb_top;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic slow = 1'b0;
    logic rx_valid_i, rx_last_i, rx_ready_o, tx_valid_o, tx_last_o, tx_ready_i, wr_en_o;
    logic [7:0] rx_data_i, tx_data_o;
    logic [15:0] rnd = 16'h9b40;
    mbw_pkg::reg_write_s wr_o;
    mbw_pkg::reg_write_s wexp[$];
    logic [8:0] texp[$];
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    modbus_write_multiple_handler DUT (.*);
    mbw_host host (.clock_i(clock_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_last_o(rx_last_i),
        .rx_ready_i(rx_ready_o), .tx_ready_o(tx_ready_i), .slow_i(slow));
    initial
        forever #2.5 clock_i = ~clock_i;
    function automatic logic [15:0] xs(input logic [15:0] x);
        x ^= x << 7;
        x ^= x >> 9;
        return x ^ (x << 8);
    endfunction : xs
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic run(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] c, input logic [7:0] bc,
        input int nw, input logic [7:0] ex);
        logic [7:0] f[$];
        logic [7:0] r[$];
        rnd = xs(rnd);
        f = {rnd[15:8], rnd[7:0], 8'h00, 8'h00, 8'h00, 8'(7 + 2 * nw), 8'h01, fn, a[15:8], a[7:0], c[15:8], c[7:0], bc};
        for (int i = 0; i < nw; i++)
        begin
            rnd = xs(rnd);
            f = {f, rnd[15:8], rnd[7:0]};
            if (ex == 8'h00)
                wexp.push_back({a + 16'(i), rnd});
        end
        if (ex == 8'h00)
            r = {f[0:4], 8'h06, 8'h01, 8'h10, f[8:11]};
        else
            r = {f[0:4], 8'h03, 8'h01, 8'h90, ex};
        foreach (r[i])
            texp.push_back({i == r.size() - 1, r[i]});
        host.send(f);
        for (int k = 0; k < 300 && texp.size() > 0; k++)
            @(posedge clock_i);
        #1;
        // a reply that never came counts as a mismatch
        chk("reply left", texp.size(), 0);
        chk("write left", wexp.size(), 0);
    endtask : run
    always @(posedge clock_i)
    begin
        cyc++;
        if (!rst_i && wr_en_o)
            chk("write", wr_o, wexp.size() > 0 ? wexp.pop_front() : 'x);
        if (!rst_i && tx_valid_o && tx_ready_i)
            chk("reply", {tx_last_o, tx_data_o}, texp.size() > 0 ? texp.pop_front() : 'x);
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end
    initial
    begin
        repeat (2) @(posedge clock_i);
        #1 rst_i = 1'b0;
        run(8'h10, 16'ha57f, 16'h0007, 8'h0e, 7, 8'h00);
        slow = 1'b1;
        run(8'h10, 16'h0000, 16'h0001, 8'h02, 1, 8'h00);
        run(8'h10, 16'hd18b, 16'h0064, 8'hc8, 100, 8'h00);
        run(8'h03, 16'h0010, 16'h0001, 8'h02, 1, 8'h01);
        slow = 1'b0;
        run(8'h10, 16'h0010, 16'h0000, 8'h00, 0, 8'h02);
        run(8'h10, 16'h0010, 16'h0065, 8'h02, 1, 8'h02);
        run(8'h10, 16'h0010, 16'h0002, 8'h03, 2, 8'h02);
        // last word would fall past the register space
        run(8'h10, 16'hffff, 16'h0002, 8'h04, 2, 8'h02);
        summarize();
    end
endmodule : modbus_write_multiple_handler_tb_top

// >>> inc/mbw_defines.svh
// constants for the write-multiple-registers handler
`ifndef MBW_DEFINES_SVH
`define MBW_DEFINES_SVH
`define PREFIX_LEN 4'h7
`define FN_WRITE_MULTI 8'h10
`define EXC_FLAG 8'h80
`define EXC_ILLEGAL_FN 8'h01
`define EXC_BAD_ADDR 8'h02
`define WORD_MIN 16'h0001
`define WORD_MAX 16'h0064
`define RESP_LEN 5'h0C
`define EXC_LEN 5'h09
`define RESP_FOLLOW 8'h06
`define EXC_FOLLOW 8'h03
`endif

// >>> inc/mbw_pkg.sv
// types for the write-multiple-registers handler
package mbw_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } reg_write_s;
    typedef enum logic [2:0] {
        ST_PREFIX,
        ST_HEAD,
        ST_DATA,
        ST_DRAIN,
        ST_REPLY
    } parse_e;
endpackage : mbw_pkg

// >>> src/modbus_write_multiple_handler.sv
// write-multiple-registers request handler, slave side
`timescale 1ns/1ps
`include "mbw_defines.svh"
module modbus_write_multiple_handler #(
    parameter logic [15:0] SPACE_LO = 16'h0000,
    parameter logic [15:0] SPACE_HI = 16'hFFFF
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // request byte stream; rx_last_i marks the last byte
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    output logic rx_ready_o,
    // reply byte stream
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    input wire logic tx_ready_i,
    // register write port
    output logic wr_en_o,
    output mbw_pkg::reg_write_s wr_o
);
    mbw_pkg::parse_e state;
    logic [4:0] idx;
    logic [7:0] prefix [0:6];
    logic [7:0] fn;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0] bcount;
    logic [15:0] wptr;
    logic [15:0] done_words;
    logic [7:0] hi_byte;
    logic lo_phase;
    logic exc;
    logic [7:0] exc_code;
    logic [4:0] tx_idx;
    logic [7:0] tx_byte;

    wire rx_take = rx_valid_i && rx_ready_o;
    wire [16:0] end_addr = {1'b0, start} + {1'b0, count} - 17'd1;
    wire count_bad = (count < `WORD_MIN) || (count > `WORD_MAX);
    // byte count must be twice word count
    wire bcount_bad = ({8'h00, bcount} != {count[14:0], 1'b0});
    // whole register space, SPACE_LO to SPACE_HI
    wire addr_bad = (start < SPACE_LO) || (end_addr > {1'b0, SPACE_HI});
    wire fn_bad = (fn != `FN_WRITE_MULTI);
    wire [4:0] tx_len = exc ? `EXC_LEN : `RESP_LEN;

    assign rx_ready_o = (state != mbw_pkg::ST_REPLY);
    assign tx_valid_o = (state == mbw_pkg::ST_REPLY);
    assign tx_last_o = tx_valid_o && (tx_idx == tx_len - 5'd1);
    assign tx_data_o = tx_byte;

    // reply byte selection, prefix copied with new length
    always_comb
    begin
        tx_byte = 8'h00;
        unique case (tx_idx)
            5'd0, 5'd1, 5'd2, 5'd3, 5'd4: tx_byte = prefix[tx_idx[2:0]];
            5'd5: tx_byte = exc ? `EXC_FOLLOW : `RESP_FOLLOW;
            5'd6: tx_byte = prefix[6];
            5'd7: tx_byte = exc ? (`EXC_FLAG | `FN_WRITE_MULTI) : fn;
            5'd8: tx_byte = exc ? exc_code : start[15:8];
            5'd9: tx_byte = start[7:0];
            5'd10: tx_byte = count[15:8];
            5'd11: tx_byte = count[7:0];
            default: tx_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state <= mbw_pkg::ST_PREFIX;
            idx <= 5'd0;
            fn <= 8'h00;
            start <= 16'h0000;
            count <= 16'h0000;
            bcount <= 8'h00;
            wptr <= 16'h0000;
            done_words <= 16'h0000;
            hi_byte <= 8'h00;
            lo_phase <= 1'b0;
            exc <= 1'b0;
            exc_code <= 8'h00;
            tx_idx <= 5'd0;
            wr_en_o <= 1'b0;
            wr_o <= '0;
            for (int i = 0; i < 7; i++)
                prefix[i] <= 8'h00;
        end
        else
        begin
            wr_en_o <= 1'b0;
            unique case (state)
                // seven prefix bytes stored for the echo
                mbw_pkg::ST_PREFIX:
                    if (rx_take)
                    begin
                        prefix[idx[2:0]] <= rx_data_i;
                        idx <= idx + 5'd1;
                        if (idx == {1'b0, `PREFIX_LEN} - 5'd1)
                        begin
                            idx <= 5'd0;
                            state <= mbw_pkg::ST_HEAD;
                        end
                        if (rx_last_i)
                        begin
                            idx <= 5'd0;
                            state <= mbw_pkg::ST_PREFIX;
                        end
                    end
                mbw_pkg::ST_HEAD:
                    if (rx_take)
                    begin
                        idx <= idx + 5'd1;
                        unique case (idx)
                            5'd0: fn <= rx_data_i;
                            5'd1: start[15:8] <= rx_data_i;
                            5'd2: start[7:0] <= rx_data_i;
                            5'd3: count[15:8] <= rx_data_i;
                            5'd4: count[7:0] <= rx_data_i;
                            default: bcount <= rx_data_i;
                        endcase
                        if (idx == 5'd0 && rx_data_i != `FN_WRITE_MULTI)
                        begin
                            exc <= 1'b1;
                            exc_code <= `EXC_ILLEGAL_FN;
                            state <= rx_last_i ? mbw_pkg::ST_REPLY : mbw_pkg::ST_DRAIN;
                        end
                        else if (idx == 5'd5)
                        begin
                            // a frame ending on the byte count carries no data: reject it
                            if (rx_last_i)
                            begin
                                exc <= 1'b1;
                                exc_code <= `EXC_BAD_ADDR;
                                state <= mbw_pkg::ST_REPLY;
                            end
                            else
                            begin
                                wptr <= start;
                                done_words <= 16'h0000;
                                lo_phase <= 1'b0;
                                state <= mbw_pkg::ST_DATA;
                            end
                        end
                        else if (rx_last_i)
                        begin
                            exc <= 1'b1;
                            exc_code <= `EXC_BAD_ADDR;
                            state <= mbw_pkg::ST_REPLY;
                        end
                    end
                    else if (idx == 5'd6 && !fn_bad)
                        idx <= idx;
                mbw_pkg::ST_DATA:
                    if (count_bad || bcount_bad || addr_bad)
                    begin
                        exc <= 1'b1;
                        exc_code <= `EXC_BAD_ADDR;
                        // the byte taken here may be the last one; draining would then hang
                        state <= (rx_take && rx_last_i) ? mbw_pkg::ST_REPLY : mbw_pkg::ST_DRAIN;
                    end
                    else if (rx_take)
                    begin
                        lo_phase <= ~lo_phase;
                        if (!lo_phase)
                            hi_byte <= rx_data_i;
                        // surplus pairs past the word count are dropped, keeping writes in the checked range
                        else if (done_words < count)
                        begin
                            wr_en_o <= 1'b1;
                            wr_o.addr <= wptr;
                            wr_o.data <= {hi_byte, rx_data_i};
                            wptr <= wptr + 16'h0001;
                            done_words <= done_words + 16'h0001;
                        end
                        if (rx_last_i)
                        begin
                            tx_idx <= 5'd0;
                            state <= mbw_pkg::ST_REPLY;
                        end
                    end
                mbw_pkg::ST_DRAIN:
                    if (rx_take && rx_last_i)
                    begin
                        tx_idx <= 5'd0;
                        state <= mbw_pkg::ST_REPLY;
                    end
                mbw_pkg::ST_REPLY:
                    if (tx_ready_i)
                    begin
                        tx_idx <= tx_idx + 5'd1;
                        if (tx_last_o)
                        begin
                            tx_idx <= 5'd0;
                            idx <= 5'd0;
                            exc <= 1'b0;
                            state <= mbw_pkg::ST_PREFIX;
                        end
                    end
            endcase
        end
    end
endmodule : modbus_write_multiple_handler
